/* File: inc/pad_mux_consts.svh */
/*
  constants for the pad function multiplexer: pad count, function count,
  field widths, reset values and the input-only pad range.
  assumes inclusion by bare name from inc/.
*/
`ifndef PAD_MUX_CONSTS_SVH
`define PAD_MUX_CONSTS_SVH

`define PAD_COUNT 40
`define FUNC_COUNT 6
`define FUNC_SEL_W 3
`define DRIVE_W 2
`define FUNC_SEL_RST 3'h0
`define DRIVE_RST 2'h2
`define INPUT_ONLY_FIRST 34
`define INPUT_ONLY_LAST 39
`define WAKE_MODE_W 2

`endif

/* File: inc/pad_mux_pkg.sv */
/*
  types for the pad function multiplexer.
  assumes pad_mux_consts.svh is on the include path.
*/
`include "pad_mux_consts.svh"

package pad_mux_pkg;
  // how a function's input behaves when another function owns the pad
  typedef enum logic [1:0] {
    IN_FOLLOW_PAD = 2'h0,
    IN_FORCE_HIGH = 2'h1,
    IN_FORCE_LOW = 2'h2
  } deselect_input_t;

  // wake-up condition on an always-on pad
  typedef enum logic [1:0] {
    WAKE_OFF = 2'h0,
    WAKE_HIGH = 2'h1,
    WAKE_LOW = 2'h2
  } wake_mode_t;

  // run state of the whole multiplexer, shared by all pads
  typedef enum logic [1:0] {
    MUX_RESET = 2'h0,
    MUX_RUN = 2'h1
  } mux_state_t;
endpackage : pad_mux_pkg

/* File: core/pad_slice.sv */
/*
  one pad of the function multiplexer: picks output value and enable from
  the selected function and forms each function's input view of the pad.
  assumes the pad level arrives already synchronised and that the caller
  holds the enable low during reset.
*/
`timescale 1ns/1ps
`default_nettype none

`include "pad_mux_consts.svh"

module pad_slice
  import pad_mux_pkg::*;
#(
  parameter int NFUNC = `FUNC_COUNT,
  parameter bit INPUT_ONLY = 1'b0,
  parameter logic [2*`FUNC_COUNT-1:0] DESEL_MODE = '0
) (
  // selection
  input wire logic [`FUNC_SEL_W-1:0] func_sel_i,
  input wire logic run_i,
  // peripheral side
  input wire logic [NFUNC-1:0] fn_out_i,
  input wire logic [NFUNC-1:0] fn_oe_i,
  output logic [NFUNC-1:0] fn_in_o,
  // pad side
  input wire logic pad_level_i,
  output logic pad_out_o,
  output logic pad_oe_o
);

  // only the selected function reaches the driver; input-only pads never drive
  always_comb begin
    pad_out_o = 1'b0;
    pad_oe_o = 1'b0;
    for (int f = 0; f < NFUNC; f++) begin
      if (func_sel_i == f[`FUNC_SEL_W-1:0]) begin // R2 R13
        pad_out_o = fn_out_i[f]; // R6
        pad_oe_o = fn_oe_i[f] & run_i & ~INPUT_ONLY; // R1 R6 R11
      end
    end
  end

  // input view per function: live pad when selected, else per deselect mode
  for (genvar g = 0; g < NFUNC; g++) begin : g_in
    always_comb begin
      if (func_sel_i == `FUNC_SEL_W'(g)) begin
        fn_in_o[g] = pad_level_i; // R7
      end else begin
        unique case (deselect_input_t'(DESEL_MODE[2*g +: 2]))
          IN_FORCE_HIGH: fn_in_o[g] = 1'b1; // R4 R7
          IN_FORCE_LOW: fn_in_o[g] = 1'b0; // R5
          default: fn_in_o[g] = pad_level_i; // R3
        endcase
      end
    end
  end
endmodule : pad_slice

`default_nettype wire

/* File: core/pad_function_mux.sv */
/*
  pad function multiplexer: up to six digital functions per pad, per-pad
  drive strength, input-only pads and wake-up from always-on pads.
  assumes one system clock; pads are asynchronous and are synchronised here;
  configuration arrives on a plain register port.
*/
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

`include "pad_mux_consts.svh"

// Behaviour
// [R1] pads 34 to 39 are inputs only, so output and pull settings never reach them.
// [R2] writing N to a pad's function select connects function N (0 to 5) to that pad.
// [R3] a plain input function keeps following the pad level while another function is selected.
// [R4] a force-high input function reads 1 while another function is selected.
// [R5] a force-low input function reads 0 while another function is selected.
// [R6] output functions drive the pad and bidirectional ones take value and enable from the peripheral.
// [R7] a bidirectional force-high function owns the pad when selected and reads 1 otherwise.
// [R8] every output pad holds a drive-strength setting of four levels with a default.
// [R9] always-on pads keep working in sleep and can wake the chip.
// [R10] after reset every function select is 0 so function 0 controls the enable.
// [R11] during reset no pad drives its output.
// [R12] drive strength is two bits, codes 0 to 3 rising, default 2.
// [R13] a function that is not selected has no effect on the pad's output or enable.
module pad_function_mux
  import pad_mux_pkg::*;
#(
  parameter int NPAD = `PAD_COUNT,
  parameter int NFUNC = `FUNC_COUNT,
  parameter logic [2*`FUNC_COUNT-1:0] DESEL_MODE = '0,
  parameter logic [`PAD_COUNT-1:0] ALWAYS_ON = '0
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // peripheral side, flattened pad-major
  input wire logic [NPAD*NFUNC-1:0] fn_out_i,
  input wire logic [NPAD*NFUNC-1:0] fn_oe_i,
  output logic [NPAD*NFUNC-1:0] fn_in_o,
  // pad side
  input wire logic [NPAD-1:0] pad_in_i,
  output logic [NPAD-1:0] pad_out_o,
  output logic [NPAD-1:0] pad_oe_o,
  output logic [NPAD*`DRIVE_W-1:0] pad_drive_o,
  // sleep and wake
  input wire logic sleep_i,
  output logic wake_o
);

  // register map: word at index p is pad p's configuration,
  // bits [2:0] function select, [5:4] drive, [9:8] wake mode;
  // index 0xFF reads the synchronised pad levels of pads 0..31
  localparam logic [7:0] LEVEL_IDX = 8'hFF;

  logic [NPAD-1:0] sync1_r;
  logic [NPAD-1:0] sync2_r;
  logic [`FUNC_SEL_W-1:0] sel_r [NPAD];
  logic [`DRIVE_W-1:0] drive_r [NPAD];
  wake_mode_t wake_r [NPAD];
  mux_state_t state_r;
  logic [NPAD-1:0] hit;
  logic [31:0] rdata_nxt;
  logic [NPAD-1:0] out_c;
  logic [NPAD-1:0] oe_c;
  logic [NPAD-1:0] out_r;
  logic [NPAD-1:0] oe_r;
  logic wake_r_o;

  // two-stage pad synchroniser
  always_ff @(posedge clk_sys_i) begin
    sync1_r <= pad_in_i;
    sync2_r <= sync1_r;
  end

  // run state: outputs stay off until reset has been released
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r <= MUX_RESET; // R11
    end else begin
      state_r <= MUX_RUN;
    end
  end

  // configuration registers, one word per pad
  for (genvar p = 0; p < NPAD; p++) begin : g_cfg
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        sel_r[p] <= `FUNC_SEL_RST; // R10
        drive_r[p] <= `DRIVE_RST; // R8 R12
        wake_r[p] <= WAKE_OFF;
      end else if (reg_wr_i && reg_addr_i == 8'(p)) begin
        if (reg_wdata_i[`FUNC_SEL_W-1:0] < NFUNC[`FUNC_SEL_W-1:0]) begin
          sel_r[p] <= reg_wdata_i[`FUNC_SEL_W-1:0]; // R2
        end
        if (!(p >= `INPUT_ONLY_FIRST && p <= `INPUT_ONLY_LAST)) begin
          drive_r[p] <= reg_wdata_i[5:4]; // R1 R8
        end
        if (ALWAYS_ON[p]) begin
          wake_r[p] <= wake_mode_t'(reg_wdata_i[9:8]); // R9
        end
      end
    end

    pad_slice #(
      .NFUNC(NFUNC),
      .INPUT_ONLY(p >= `INPUT_ONLY_FIRST && p <= `INPUT_ONLY_LAST),
      .DESEL_MODE(DESEL_MODE)
    ) u_slice (
      .func_sel_i(sel_r[p]),
      .run_i(state_r == MUX_RUN),
      .fn_out_i(fn_out_i[p*NFUNC +: NFUNC]),
      .fn_oe_i(fn_oe_i[p*NFUNC +: NFUNC]),
      .fn_in_o(fn_in_o[p*NFUNC +: NFUNC]),
      .pad_level_i(sync2_r[p]),
      .pad_out_o(out_c[p]),
      .pad_oe_o(oe_c[p])
    );

    assign pad_drive_o[p*`DRIVE_W +: `DRIVE_W] = drive_r[p]; // R12

    // wake condition on always-on pads while sleeping
    always_comb begin
      hit[p] = 1'b0;
      if (ALWAYS_ON[p] && sleep_i) begin
        unique case (wake_r[p])
          WAKE_HIGH: hit[p] = sync2_r[p]; // R9
          WAKE_LOW: hit[p] = ~sync2_r[p]; // R9
          default: hit[p] = 1'b0;
        endcase
      end
    end
  end

  // pad drivers registered; off while in reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      out_r <= '0;
      oe_r <= '0; // R11
    end else begin
      out_r <= out_c;
      oe_r <= oe_c & ~({NPAD{sleep_i}} & ~ALWAYS_ON); // R9
    end
  end

  assign pad_out_o = out_r;
  assign pad_oe_o = oe_r;

  // wake request registered
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wake_r_o <= 1'b0;
    end else begin
      wake_r_o <= |hit; // R9
    end
  end

  assign wake_o = wake_r_o;

  // read mux
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_addr_i == LEVEL_IDX) begin
      for (int i = 0; i < NPAD && i < 32; i++) begin
        rdata_nxt[i] = sync2_r[i];
      end
    end else begin
      for (int i = 0; i < NPAD; i++) begin
        if (reg_addr_i == i[7:0]) begin
          rdata_nxt[`FUNC_SEL_W-1:0] = sel_r[i];
          rdata_nxt[5:4] = drive_r[i];
          rdata_nxt[9:8] = wake_r[i];
        end
      end
    end
  end

  // read data stand one cycle after the strobe only
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end
endmodule : pad_function_mux

`default_nettype wire

/* File: verif/pad_mux_checker_sva.sv */
/*
  assertions on the pad multiplexer ports.
  assumes function 1 forces high, 2 forces low, 3 follows; pad 0 is always-on.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_mux_checker #(parameter int NPAD = 40, parameter int NFUNC = 6) (
  // clock, reset and register port
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // peripheral and pad side
  input wire logic [NPAD*NFUNC-1:0] fn_out_i,
  input wire logic [NPAD*NFUNC-1:0] fn_oe_i,
  input wire logic [NPAD*NFUNC-1:0] fn_in_o,
  input wire logic [NPAD-1:0] pad_in_i,
  input wire logic [NPAD-1:0] pad_out_o,
  input wire logic [NPAD-1:0] pad_oe_o,
  input wire logic [NPAD*2-1:0] pad_drive_o,
  input wire logic sleep_i,
  input wire logic wake_o
);
  logic [2:0] sel0_r;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // shadow of pad 0 select; out-of-range codes are dropped
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) sel0_r <= 3'h0;
    else if (reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[2:0] < 3'h6) sel0_r <= reg_wdata_i[2:0];
  end
  a_input_only_quiet: assert property (pad_oe_o[39:34] == 6'h00)
    else $error("input-only pad driven");
  a_reset_quiet: assert property ($fell(sys_rst_i) |-> pad_oe_o == '0 ##1 pad_oe_o == '0)
    else $error("pad driven at reset");
  a_default_drive: assert property ($fell(sys_rst_i) |-> pad_drive_o == {NPAD{2'h2}})
    else $error("drive default wrong");
  a_reset_select: assert property ($fell(sys_rst_i) |-> fn_in_o[1] && !fn_in_o[2])
    else $error("select not zero after reset");
  a_out_follow: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
    pad_oe_o[0] == $past(fn_oe_i[sel0_r]) && pad_out_o[0] == $past(fn_out_i[sel0_r]))
    else $error("pad 0 not from selected function");
  a_follow_pad: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
    fn_in_o[3] == $past(pad_in_i[0], 2))
    else $error("plain input lost pad");
  a_readback_sel: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h00 |-> reg_rdata_o[2:0] == sel0_r)
    else $error("select readback wrong");
  a_sleep_gate: assert property ($past(sleep_i) && !$past(sys_rst_i) |-> pad_oe_o[33:1] == '0)
    else $error("pad driven in sleep");
  a_wake_idle: assert property (!$past(sleep_i) |-> !wake_o)
    else $error("wake while awake");
endmodule : pad_mux_checker
bind pad_function_mux pad_mux_checker #(.NPAD(NPAD), .NFUNC(NFUNC)) u_chk (.clk_sys_i, .sys_rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fn_out_i, .fn_oe_i, .fn_in_o, .pad_in_i, .pad_out_o,
  .pad_oe_o, .pad_drive_o, .sleep_i, .wake_o);
`default_nettype wire

/* File: verif/periph_pad_model.sv */
/*
  peripherals and pads around the multiplexer.
  assumes an undriven pad sits at the level the bench asks for.
*/
`timescale 1ns/1ps
`default_nettype none
module periph_pad_model #(parameter int NPAD = 40, parameter int NFUNC = 6) (
  // bench control
  input wire logic [NFUNC-1:0] fn_en_i,
  input wire logic lvl_i,
  // multiplexer side
  input wire logic [NPAD-1:0] pad_out_i,
  input wire logic [NPAD-1:0] pad_oe_i,
  output logic [NPAD*NFUNC-1:0] fn_out_o,
  output logic [NPAD*NFUNC-1:0] fn_oe_o,
  output logic [NPAD-1:0] pad_lvl_o
);
  // each function drives the inverse of its enable; a driven pad reads back
  assign fn_oe_o = {NPAD{fn_en_i}};
  assign fn_out_o = {NPAD{~fn_en_i}};
  assign pad_lvl_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & {NPAD{lvl_i}});
endmodule : periph_pad_model
`default_nettype wire

/* File: verif/pad_function_mux_test.sv */
/*
  directed bench for the pad multiplexer.
  assumes the checker is bound and the peripheral model stands beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module pad_function_mux_test;
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, sleep = 1'b0, lvl = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [5:0] en = 6'h00;
  logic [31:0] rdata;
  logic [239:0] fn_out, fn_oe, fn_in;
  logic [39:0] pad_in, pad_out, pad_oe;
  logic [79:0] drive;
  logic wake;
  int fails = 0;
  int comparisons = 0;
  pad_function_mux #(.DESEL_MODE(12'h024), .ALWAYS_ON(40'h1)) dut (.clk_sys_i(clk), .sys_rst_i(rst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .fn_out_i(fn_out), .fn_oe_i(fn_oe), .fn_in_o(fn_in), .pad_in_i(pad_in), .pad_out_o(pad_out),
    .pad_oe_o(pad_oe), .pad_drive_o(drive), .sleep_i(sleep), .wake_o(wake));
  periph_pad_model pm (.fn_en_i(en), .lvl_i(lvl), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .fn_out_o(fn_out), .fn_oe_o(fn_oe), .pad_lvl_o(pad_in));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle strobes, changed right after the edge
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= w;
    rd_s <= !w;
    @(posedge clk);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    #1 if (!w) chk(rdata, d);
  endtask : access
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic final_report();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    #(25 * 4000);
    fails++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    access(1'b0, 8'h05, 32'h20);
    // read data stand for one cycle only, then fall back to zero
    cyc(1);
    chk(rdata, 32'h0000_0000);
    access(1'b0, 8'h24, 32'h20);
    access(1'b0, 8'hFE, 32'h00);
    en <= 6'h2A;
    // every function on pad 5 with a matching drive code
    for (int s = 0; s < 6; s++) begin
      access(1'b1, 8'h05, 32'(s) | 32'((s % 4) << 4));
      cyc(2);
      chk(32'(pad_oe[5]), 32'(en[s]));
      chk(32'(pad_out[5]), 32'(!en[s]));
      chk(32'(drive[11:10]), 32'(s % 4));
      access(1'b0, 8'h05, 32'(s) | 32'((s % 4) << 4));
    end
    access(1'b1, 8'h05, 32'h37);
    access(1'b0, 8'h05, 32'h35);
    en <= 6'h3F;
    access(1'b1, 8'h24, 32'h01);
    cyc(2);
    chk(32'(pad_oe[36]), 32'h0);
    access(1'b0, 8'h24, 32'h21);
    // deselected inputs on pad 5 with the pad released
    en <= 6'h00;
    access(1'b1, 8'h05, 32'h20);
    for (int l = 0; l < 2; l++) begin
      lvl <= l[0];
      cyc(3);
      chk(32'(fn_in[31]), 32'h1);
      chk(32'(fn_in[32]), 32'h0);
      chk(32'(fn_in[33]), 32'(l));
    end
    // every released pad of the low word reads back high through the level word
    access(1'b0, 8'hFF, 32'hFFFF_FFFF);
    access(1'b1, 8'h05, 32'h21);
    lvl <= 1'b0;
    cyc(3);
    chk(32'(fn_in[31]), 32'h0);
    // sleep gating and wake from pad 0
    en <= 6'h01;
    access(1'b1, 8'h00, 32'h120);
    // wake mode is dropped on a pad that is not always-on
    access(1'b1, 8'h01, 32'h120);
    access(1'b0, 8'h01, 32'h20);
    sleep <= 1'b1;
    cyc(2);
    chk(32'(pad_oe[1]), 32'h0);
    chk(32'(pad_oe[0]), 32'h1);
    chk(32'(wake), 32'h0);
    @(posedge clk);
    en <= 6'h00;
    lvl <= 1'b1;
    cyc(5);
    chk(32'(wake), 32'h1);
    // wake on low level: quiet while the pad is high, asserted once it falls
    access(1'b1, 8'h00, 32'h220);
    cyc(1);
    chk(32'(wake), 32'h0);
    lvl <= 1'b0;
    cyc(4);
    chk(32'(wake), 32'h1);
    @(posedge clk);
    sleep <= 1'b0;
    en <= 6'h3F;
    rst <= 1'b1;
    cyc(3);
    chk(32'(|pad_oe), 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    access(1'b0, 8'h05, 32'h20);
    final_report();
  end
endmodule : pad_function_mux_test
`default_nettype wire
